/* rtl/sfq_pkg.sv */
package sfq_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int SCLK_HALF_NS = 16;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_SETUP_NS = 8;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_HIGH_NS = 20;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 4;
  localparam int DIV_W = 4;

  // ****************************************
  // flash opcodes
  // ****************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_SECTOR_WIPE_ALT = 8'h21;
  localparam logic [7:0] OP_SMALL_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_SMALL_BLOCK_WIPE_ALT = 8'h5C;
  localparam logic [7:0] OP_LARGE_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OP_LARGE_BLOCK_WIPE_ALT = 8'hDC;
  localparam logic [7:0] OP_ARRAY_WIPE = 8'h60;
  localparam logic [7:0] OP_ARRAY_WIPE_ALT = 8'hC7;
  localparam logic [7:0] OP_QUAD_CMD_ON = 8'h38;
  localparam logic [7:0] OP_QUAD_CMD_OFF = 8'hFF;

  // flash status byte
  localparam int FST_WIP_BIT = 0;
  localparam int FST_WEL_BIT = 1;

  // frame geometry
  localparam logic [2:0] ADDR_BYTES_STD = 3'h3;
  localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;
  localparam logic [3:0] SERIAL_BEATS = 4'h8;
  localparam logic [3:0] QUAD_BEATS = 4'h2;

  // ****************************************
  // register map
  // ****************************************
  localparam int AVS_ADDR_W = 4;
  localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [AVS_ADDR_W-1:0] REG_ADDR = 4'h4;
  localparam logic [AVS_ADDR_W-1:0] REG_CFG = 4'h8;
  localparam logic [AVS_ADDR_W-1:0] REG_STAT = 4'hC;

  localparam int CTRL_ORDER_LSB = 0;
  localparam int CTRL_ALT_BIT = 3;
  localparam int CTRL_GO_BIT = 8;
  localparam int CFG_WIDE_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_QUAD_BIT = 1;
  localparam int STAT_WIP_BIT = 2;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_REFUSED_BIT = 4;
  localparam int STAT_BYTE_LSB = 8;

  typedef enum logic [2:0] {
    ORD_SECTOR = 3'h0,
    ORD_SMALL_BLOCK = 3'h1,
    ORD_LARGE_BLOCK = 3'h2,
    ORD_ARRAY = 3'h3,
    ORD_QUAD_ON = 3'h4,
    ORD_QUAD_OFF = 3'h5
  } sfq_order_t;

endpackage : sfq_pkg

/* rtl/sfq_shift.sv */
`timescale 1ns/10ps
module sfq_shift
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte request
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic quad,
  input wire logic rx_mode,
  output logic done,
  output logic [7:0] rx_byte,
  // pins, input already synchronised
  input wire logic [3:0] io_in_s,
  output logic sclk,
  output logic [3:0] io_out,
  output logic [3:0] io_oe
);
  import sfq_pkg::*;

  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic [DIV_W-1:0] div_r;
  logic busy_r;
  logic sclk_r;
  logic done_r;
  logic rx_mode_r;
  logic quad_r;
  logic [7:0] rx_r;

  // ****************************************
  // beat engine, mode 0: data set while sclk low
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      div_r <= '0;
      busy_r <= 1'b0;
      sclk_r <= 1'b0;
      done_r <= 1'b0;
      rx_mode_r <= 1'b0;
      quad_r <= 1'b0;
      rx_r <= 8'h00;
    end
    else
    begin
      done_r <= 1'b0;
      if (start)
      begin
        sh_r <= tx_byte;
        cnt_r <= quad ? QUAD_BEATS : SERIAL_BEATS;
        div_r <= DIV_W'(SCLK_HALF_CYC - 1);
        busy_r <= 1'b1;
        sclk_r <= 1'b0;
        rx_mode_r <= rx_mode;
        quad_r <= quad;
      end
      else if (busy_r)
      begin
        if (div_r == '0)
        begin
          div_r <= DIV_W'(SCLK_HALF_CYC - 1);
          if (!sclk_r)
          begin
            sclk_r <= 1'b1;
            // sampled late in the low phase so the sync delay is covered
            rx_r <= quad_r ? {rx_r[3:0], io_in_s} : {rx_r[6:0], io_in_s[1]};
          end
          else
          begin
            sclk_r <= 1'b0;
            sh_r <= quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1)
            begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
        else
          div_r <= div_r - DIV_W'(1);
      end
    end
  end

  assign done = done_r;
  assign rx_byte = rx_r;
  assign sclk = sclk_r;
  // serial mode keeps the protect and hold lines high
  assign io_out = quad ? sh_r[7:4] : {2'b11, 1'b0, sh_r[7]};
  assign io_oe = quad ? ((busy_r && !rx_mode_r) ? 4'hF : 4'h0) : {2'b11, 1'b0, !(busy_r && rx_mode_r)};

endmodule : sfq_shift

/* rtl/sfq_host.sv */
`timescale 1ns/10ps
// Summary of operation
// - sector wipe is sent with opcode 20H or the alternative 21H.
// - a write enable frame always precedes every wipe frame.
// - chip select stays low for opcode and three or four address bytes.
// - chip select rises right after the last address bit, else command cancelled.
// - the host polls the status byte until write in progress clears.
// - small block wipe is sent with opcode 52H or 5CH.
// - large block wipe is sent with opcode D8H or DCH.
// - array wipe is opcode only, 60H or C7H, then chip select rises.
// - opcode 38H in serial mode enters four line command mode.
// - opcode FFH leaves four line command mode back to serial.
module sfq_host
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [sfq_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // flash pins
  output logic flash_cs_n,
  output logic flash_sclk,
  input wire logic [3:0] flash_io_in,
  output logic [3:0] flash_io_out,
  output logic [3:0] flash_io_oe
);
  import sfq_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_SEND, ST_WAIT, ST_HOLD} sfq_state_t;
  typedef enum logic [1:0] {FR_WRITE_ENABLE_CMD, FR_WIPE, FR_POLL, FR_MODE} sfq_frame_t;

  sfq_state_t state_r;
  sfq_frame_t frame_r;
  sfq_order_t order_r;
  logic alt_r;
  logic [31:0] addr_r;
  logic wide_r;
  logic [31:0] cmd_addr_r;
  logic cmd_wide_r;
  logic [2:0] idx_r;
  logic [TMR_W-1:0] tmr_r;
  logic cs_n_r;
  logic quad_mode_r;
  logic [7:0] fstat_r;
  logic done_flag_r;
  logic refused_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [3:0] io_s1_r;
  logic [3:0] io_s2_r;
  logic sh_done;
  logic [7:0] sh_rx;
  logic bus_req;
  logic wr_acc;
  logic go_req;
  logic go_take;
  logic go_bad;
  logic last_byte;
  logic frame_end;
  logic op_finish;
  logic [2:0] frame_len;
  logic [7:0] tx_byte;
  logic rx_phase;
  logic is_wipe;
  logic [2:0] ord_code;

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end
    else
    begin
      io_s1_r <= flash_io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // ****************************************
  // avalon slave, one wait cycle per access
  // ****************************************
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_r;
  assign wr_acc = avs_write && ack_r;
  assign go_req = wr_acc && avs_address == REG_CTRL && avs_byteenable[1] && avs_writedata[CTRL_GO_BIT];
  // an order written in the same access as go must be judged by the new code, not the stored one
  assign ord_code = (wr_acc && avs_address == REG_CTRL && avs_byteenable[0]) ?
                    avs_writedata[CTRL_ORDER_LSB +: 3] : order_r;
  assign is_wipe = ord_code inside {ORD_SECTOR, ORD_SMALL_BLOCK, ORD_LARGE_BLOCK, ORD_ARRAY};
  // entering four line mode from four line mode is meaningless, and busy blocks new orders
  assign go_bad = state_r != ST_IDLE || (ord_code == ORD_QUAD_ON && quad_mode_r) || ord_code > ORD_QUAD_OFF;
  assign go_take = go_req && !go_bad;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req && !ack_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      order_r <= ORD_SECTOR;
      alt_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      wide_r <= 1'b0;
    end
    else if (wr_acc)
    begin
      unique case (avs_address)
        REG_CTRL:
        begin
          if (avs_byteenable[0] && state_r == ST_IDLE)
          begin
            order_r <= sfq_order_t'(avs_writedata[CTRL_ORDER_LSB +: 3]);
            alt_r <= avs_writedata[CTRL_ALT_BIT];
          end
        end
        REG_ADDR:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (avs_byteenable[b])
              addr_r[8*b +: 8] <= avs_writedata[8*b +: 8];
          end
        end
        REG_CFG:
        begin
          if (avs_byteenable[0])
            wide_r <= avs_writedata[CFG_WIDE_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (avs_read && !ack_r)
    begin
      rdata_r <= 32'h0000_0000;
      unique case (avs_address)
        REG_CTRL:
        begin
          rdata_r[CTRL_ORDER_LSB +: 3] <= order_r;
          rdata_r[CTRL_ALT_BIT] <= alt_r;
        end
        REG_ADDR:
          rdata_r <= addr_r;
        REG_CFG:
          rdata_r[CFG_WIDE_BIT] <= wide_r;
        REG_STAT:
        begin
          rdata_r[STAT_BUSY_BIT] <= state_r != ST_IDLE;
          rdata_r[STAT_QUAD_BIT] <= quad_mode_r;
          rdata_r[STAT_WIP_BIT] <= fstat_r[FST_WIP_BIT];
          rdata_r[STAT_DONE_BIT] <= done_flag_r;
          rdata_r[STAT_REFUSED_BIT] <= refused_r;
          rdata_r[STAT_BYTE_LSB +: 8] <= fstat_r;
        end
        default:
        begin
        end
      endcase
    end
  end
  assign avs_readdata = rdata_r;

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_flag_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      if (op_finish)
        done_flag_r <= 1'b1;
      else if (wr_acc && avs_address == REG_STAT && avs_byteenable[0] && avs_writedata[STAT_DONE_BIT])
        done_flag_r <= 1'b0;
      if (go_req && go_bad)
        refused_r <= 1'b1;
      else if (wr_acc && avs_address == REG_STAT && avs_byteenable[0] && avs_writedata[STAT_REFUSED_BIT])
        refused_r <= 1'b0;
    end
  end

  // ****************************************
  // frame contents
  // ****************************************
  always_comb
  begin
    unique case (frame_r)
      FR_WIPE:
        if (order_r == ORD_ARRAY)
          frame_len = 3'h1;
        else
          frame_len = 3'h1 + (cmd_wide_r ? ADDR_BYTES_WIDE : ADDR_BYTES_STD);
      FR_POLL:
        frame_len = 3'h2;
      default:
        frame_len = 3'h1;
    endcase
  end

  always_comb
  begin
    tx_byte = 8'h00;
    unique case (frame_r)
      FR_WRITE_ENABLE_CMD:
        tx_byte = OP_WRITE_ENABLE;
      FR_POLL:
        tx_byte = OP_READ_STATUS;
      FR_MODE:
        tx_byte = (order_r == ORD_QUAD_ON) ? OP_QUAD_CMD_ON : OP_QUAD_CMD_OFF;
      FR_WIPE:
      begin
        if (idx_r == 3'h0)
        begin
          unique case (order_r)
            ORD_SECTOR:
              tx_byte = alt_r ? OP_SECTOR_WIPE_ALT : OP_SECTOR_WIPE;
            ORD_SMALL_BLOCK:
              tx_byte = alt_r ? OP_SMALL_BLOCK_WIPE_ALT : OP_SMALL_BLOCK_WIPE;
            ORD_LARGE_BLOCK:
              tx_byte = alt_r ? OP_LARGE_BLOCK_WIPE_ALT : OP_LARGE_BLOCK_WIPE;
            ORD_ARRAY:
              tx_byte = alt_r ? OP_ARRAY_WIPE_ALT : OP_ARRAY_WIPE;
            default:
              tx_byte = 8'h00;
          endcase
        end
        // address passed unmasked, most significant byte first
        else
          tx_byte = cmd_addr_r[8*(frame_len - idx_r - 3'h1) +: 8];
      end
      default:
        tx_byte = 8'h00;
    endcase
  end

  assign rx_phase = frame_r == FR_POLL && idx_r == 3'h1;
  assign last_byte = idx_r == frame_len - 3'h1;
  assign frame_end = state_r == ST_WAIT && sh_done && last_byte;
  // keep polling while write in progress reads one
  assign op_finish = state_r == ST_HOLD && tmr_r == '0 &&
                     (frame_r == FR_MODE || (frame_r == FR_POLL && !fstat_r[FST_WIP_BIT]));

  // ****************************************
  // frame sequencer
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      frame_r <= FR_WRITE_ENABLE_CMD;
      idx_r <= 3'h0;
      tmr_r <= '0;
      cs_n_r <= 1'b1;
      cmd_addr_r <= 32'h0000_0000;
      cmd_wide_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (go_take)
          begin
            frame_r <= is_wipe ? FR_WRITE_ENABLE_CMD : FR_MODE;
            cmd_addr_r <= addr_r;
            cmd_wide_r <= wide_r;
            idx_r <= 3'h0;
            cs_n_r <= 1'b0;
            tmr_r <= TMR_W'(CS_SETUP_CYC - 1);
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (tmr_r == '0)
            state_r <= ST_SEND;
          else
            tmr_r <= tmr_r - TMR_W'(1);
        end
        ST_SEND:
          state_r <= ST_WAIT;
        ST_WAIT:
        begin
          if (sh_done)
          begin
            // select held through the frame, raised right after its last bit
            if (last_byte)
            begin
              cs_n_r <= 1'b1;
              tmr_r <= TMR_W'(CS_HIGH_CYC - 1);
              state_r <= ST_HOLD;
            end
            else
            begin
              idx_r <= idx_r + 3'h1;
              state_r <= ST_SEND;
            end
          end
        end
        ST_HOLD:
        begin
          if (tmr_r != '0)
            tmr_r <= tmr_r - TMR_W'(1);
          else if (op_finish)
            state_r <= ST_IDLE;
          else
          begin
            // wipe runs from the rising select; poll next
            frame_r <= (frame_r == FR_WRITE_ENABLE_CMD) ? FR_WIPE : FR_POLL;
            idx_r <= 3'h0;
            cs_n_r <= 1'b0;
            tmr_r <= TMR_W'(CS_SETUP_CYC - 1);
            state_r <= ST_SETUP;
          end
        end
      endcase
    end
  end

  // ****************************************
  // mode and status tracking
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      quad_mode_r <= 1'b0;
    // mode follows the completed switch frame
    else if (frame_end && frame_r == FR_MODE)
      quad_mode_r <= order_r == ORD_QUAD_ON;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fstat_r <= 8'h00;
    else if (frame_end && frame_r == FR_POLL)
      fstat_r <= sh_rx;
  end

  sfq_shift u_shift
  (
    .clk(clk),
    .rst_n(rst_n),
    .start(state_r == ST_SEND),
    .tx_byte(tx_byte),
    .quad(quad_mode_r),
    .rx_mode(rx_phase),
    .done(sh_done),
    .rx_byte(sh_rx),
    .io_in_s(io_s2_r),
    .sclk(flash_sclk),
    .io_out(flash_io_out),
    .io_oe(flash_io_oe)
  );

  assign flash_cs_n = cs_n_r;

endmodule : sfq_host

/* tb/sfq_host_properties.sv */
`timescale 1ns/10ps
module sfq_host_properties
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic [sfq_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // flash pins
  input wire logic flash_cs_n,
  input wire logic flash_sclk,
  input wire logic [3:0] flash_io_out,
  input wire logic [3:0] flash_io_oe
);
  import sfq_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    !flash_sclk [*2];
  endsequence
  sequence s_half;
    flash_sclk [*4] ##1 !flash_sclk;
  endsequence
  property p_cs_setup;
    $fell(flash_cs_n) |-> s_setup;
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("sclk moved during select setup");
  property p_sclk_half;
    $rose(flash_sclk) |-> s_half;
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase not four cycles");
  property p_cs_idle;
    flash_cs_n |-> !flash_sclk;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("sclk high while deselected");
  property p_cs_gap;
    $rose(flash_cs_n) |-> flash_cs_n [*5];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("deselect gap too short");
  property p_cs_after;
    $rose(flash_cs_n) |-> $past(!flash_sclk);
  endproperty
  a_cs_after: assert property (p_cs_after) else $error("select released in mid bit");
  property p_io_hold;
    flash_sclk && $past(flash_sclk) |-> $stable(flash_io_out & flash_io_oe);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("data moved while sclk high");
  property p_idle_oe;
    flash_cs_n |-> flash_io_oe inside {4'hD, 4'h0};
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("bad idle enables");
  property p_serial_hi;
    flash_io_oe inside {4'hD, 4'hC} |-> flash_io_out[3:2] == 2'h3;
  endproperty
  a_serial_hi: assert property (p_serial_hi) else $error("upper lines not high in serial");
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : sfq_host_properties

bind sfq_host sfq_host_properties u_sfq_host_properties (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .flash_cs_n, .flash_sclk, .flash_io_out, .flash_io_oe);

/* tb/sfq_flash_model.sv */
`timescale 1ns/10ps
module sfq_flash_model
#(
  parameter int SEC_T = 60,
  parameter int BLK1_T = 80,
  parameter int BLK2_T = 100,
  parameter int CHIP_T = 150
)
(
  // clock and pins
  input wire logic clk,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io,
  output logic [3:0] io_out,
  // setup
  input wire logic [4:0] prot,
  input wire logic wide,
  input wire logic susp,
  // observation
  output logic quad,
  output logic write_in_progress,
  output logic [7:0] last_op,
  output logic [31:0] last_addr,
  output int wipes
);
  import sfq_pkg::*;
  logic [39:0] sh;
  logic [7:0] op;
  logic [7:0] sts;
  logic write_enable_latch;
  int n;
  int tmr;
  initial
  begin
    {n, wipes, tmr} = '0;
    {quad, write_in_progress, write_enable_latch, op, sts, sh, last_op, last_addr, io_out} = '0;
  end
  always @(negedge cs_n) n = 0;
  // bits in, one or four lines
  always @(posedge sclk)
  begin
    if (!cs_n)
    begin
      sh = quad ? {sh[35:0], io} : {sh[38:0], io[0]};
      n = n + (quad ? 4 : 1);
      if (n == 8)
      begin
        op = sh[7:0];
        sts = {6'h0, write_enable_latch, write_in_progress};
      end
    end
  end
  always @(negedge sclk)
  begin
    if (!cs_n && n >= 8 && op == OP_READ_STATUS)
    begin
      io_out = quad ? sts[7:4] : {2'h0, sts[7], 1'h0};
      sts = quad ? sts << 4 : sts << 1;
    end
  end
  task automatic go(input int t, input logic ok);
    if (write_enable_latch && ok && !susp)
    begin
      write_in_progress = 1'b1;
      tmr = t;
      write_enable_latch = 1'b0;
      wipes++;
      last_op = op;
      last_addr = wide ? sh[31:0] : {8'h0, sh[23:0]};
    end
  endtask : go
  always @(posedge cs_n)
  begin
    // released lines show the inverse of the last value
    io_out = ~io_out;
    if (!write_in_progress && n == 8)
      case (op)
        OP_WRITE_ENABLE: write_enable_latch = 1'b1;
        OP_QUAD_CMD_ON: quad = 1'b1;
        OP_QUAD_CMD_OFF: quad = 1'b0;
        OP_ARRAY_WIPE, OP_ARRAY_WIPE_ALT: go(CHIP_T, prot == 5'h0);
        default: ;
      endcase
    else if (!write_in_progress && n == (wide ? 40 : 32))
      case (op)
        OP_SECTOR_WIPE, OP_SECTOR_WIPE_ALT: go(SEC_T, prot == 5'h0);
        OP_SMALL_BLOCK_WIPE, OP_SMALL_BLOCK_WIPE_ALT: go(BLK1_T, prot == 5'h0);
        OP_LARGE_BLOCK_WIPE, OP_LARGE_BLOCK_WIPE_ALT: go(BLK2_T, prot == 5'h0);
        default: ;
      endcase
  end
  always @(posedge clk)
  begin
    if (write_in_progress)
    begin
      tmr = tmr - 1;
      if (tmr == 0)
        write_in_progress = 1'b0;
    end
  end
endmodule : sfq_flash_model

/* tb/test_sfq_host.sv */
`timescale 1ns/10ps
module test_sfq_host;
  import sfq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic flash_cs_n;
  logic flash_sclk;
  logic [3:0] io_in_w;
  logic [3:0] io_out_w;
  logic [3:0] io_oe_w;
  logic [3:0] mdl_out;
  logic [4:0] prot = 5'h0;
  logic wide = 1'b0;
  logic susp = 1'b0;
  logic quad;
  logic write_in_progress;
  logic [7:0] last_op;
  logic [31:0] last_addr;
  logic [31:0] s;
  int wipes;
  int w0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] ops [8] = '{OP_SECTOR_WIPE, OP_SECTOR_WIPE_ALT, OP_SMALL_BLOCK_WIPE, OP_SMALL_BLOCK_WIPE_ALT,
    OP_LARGE_BLOCK_WIPE, OP_LARGE_BLOCK_WIPE_ALT, OP_ARRAY_WIPE, OP_ARRAY_WIPE_ALT};

  always #2 clk = ~clk;
  // each line carries whoever enables it
  assign io_in_w = (io_oe_w & io_out_w) | (~io_oe_w & mdl_out);

  sfq_host u_sfq_host (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .flash_cs_n, .flash_sclk, .flash_io_in(io_in_w), .flash_io_out(io_out_w),
    .flash_io_oe(io_oe_w));
  sfq_flash_model u_sfq_flash_model (.clk, .cs_n(flash_cs_n), .sclk(flash_sclk), .io(io_in_w),
    .io_out(mdl_out), .prot, .wide, .susp, .quad, .write_in_progress, .last_op, .last_addr, .wipes);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // entered just after a rising edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 50)
    begin
      error_cnt++;
      results();
    end
    @(posedge clk);
  endtask : bus
  task automatic run(input logic [2:0] ord, input logic alt);
    int t;
    bus(1'b0, REG_STAT, 32'h18, s);
    bus(1'b0, REG_CTRL, 32'h100 | {alt, ord}, s);
    t = 0;
    do
    begin
      bus(1'b1, REG_STAT, 32'h0, s);
      t++;
    end
    while (s[STAT_BUSY_BIT] !== 1'b0 && t < 2000);
    if (t >= 2000)
    begin
      error_cnt++;
      results();
    end
  endtask : run
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial
  begin
    #400000;
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, REG_STAT, 32'h0, s);
    chk("stat_rst", s, 32'h0);
    bus(1'b1, REG_CFG, 32'h0, s);
    chk("cfg_rst", s, 32'h0);
    bus(1'b1, 4'h6, 32'h0, s);
    chk("unmapped", s, 32'h0);
    $display("test reset done");
    // every wipe opcode, narrow then wide address
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b0, REG_CFG, 32'(m), s);
      wide <= m[0];
      for (int k = 0; k < 8; k++)
      begin
        w0 = wipes;
        bus(1'b0, REG_ADDR, 32'h12ABCDEF, s);
        run(3'(k / 2), 1'(k % 2));
        chk("opcode", last_op, ops[k]);
        chk("count", 32'(wipes), 32'(w0 + 1));
        if (k < 6)
          chk("addr", last_addr, m ? 32'h12ABCDEF : 32'h00ABCDEF);
        chk("wip", {s[STAT_WIP_BIT], write_in_progress}, 32'h0);
        chk("wel", s[STAT_BYTE_LSB + FST_WEL_BIT], 32'h0);
        chk("done", s[STAT_DONE_BIT], 32'h1);
      end
    end
    bus(1'b0, REG_CFG, 32'h0, s);
    wide <= 1'b0;
    $display("test wipes done");
    // protected array refuses all kinds
    prot <= 5'h1;
    w0 = wipes;
    for (int o = 0; o < 4; o++)
    begin
      run(3'(o), 1'b0);
      chk("prot_count", 32'(wipes), 32'(w0));
      chk("prot_wel", s[STAT_BYTE_LSB + FST_WEL_BIT], 32'h1);
    end
    prot <= 5'h0;
    // suspended wipe must be refused even with the latch set
    susp <= 1'b1;
    run(3'(ORD_SECTOR), 1'b0);
    chk("susp_count", 32'(wipes), 32'(w0));
    susp <= 1'b0;
    $display("test protect done");
    // four line command mode round trip
    run(3'(ORD_QUAD_ON), 1'b0);
    chk("quad_on", {s[STAT_QUAD_BIT], quad}, 32'h3);
    bus(1'b0, REG_ADDR, 32'h00012345, s);
    run(3'(ORD_SMALL_BLOCK), 1'b1);
    chk("quad_op", last_op, OP_SMALL_BLOCK_WIPE_ALT);
    chk("quad_addr", last_addr, 32'h00012345);
    run(3'(ORD_QUAD_ON), 1'b0);
    chk("quad_again", s[STAT_REFUSED_BIT], 32'h1);
    run(3'(ORD_QUAD_OFF), 1'b0);
    chk("quad_off", {s[STAT_QUAD_BIT], quad}, 32'h0);
    run(3'(ORD_SECTOR), 1'b0);
    chk("serial_op", last_op, OP_SECTOR_WIPE);
    $display("test quad done");
    results();
  end
endmodule : test_sfq_host
